/* File: hw/math_trap_pkg.sv */
/*
  constants for the math trap status and control block: register offsets,
  bit positions and reset values.
  assumes a 32-bit apb with word-aligned registers.
*/
`default_nettype none
package math_trap_pkg;
  // =====================================================================
  // register map
  localparam logic [7:0]  OFF_TRAP_CTRL   = 8'h00;
  localparam logic [7:0]  OFF_IRQ_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_IRQ_MASK    = 8'h08;
  // =====================================================================
  // trap control/status bit positions
  localparam int BIT_NEST_DIS  = 15;
  localparam int BIT_OVA_FLAG  = 14;
  localparam int BIT_OVB_FLAG  = 13;
  localparam int BIT_COVA_FLAG = 12;
  localparam int BIT_COVB_FLAG = 11;
  localparam int BIT_OVA_EN    = 10;
  localparam int BIT_OVB_EN    = 9;
  localparam int BIT_COV_EN    = 8;
  localparam int BIT_SHIFT     = 7;
  localparam int BIT_DIV0      = 6;
  localparam int BIT_DMA       = 5;
  localparam int BIT_ARITH     = 4;
  localparam logic [15:0] TRAP_RESET = 16'h0000;
  // writable control bits (nesting disable and the three enables)
  localparam logic [15:0] CTRL_MASK  = 16'h8700;
  // flag bits: sticky, cleared by software writing zero
  localparam logic [15:0] FLAG_MASK  = 16'h78f0;
  // =====================================================================
  // interrupt status bits
  localparam int IRQ_BITS      = 6;
  localparam int IRQ_OVA       = 0;
  localparam int IRQ_OVB       = 1;
  localparam int IRQ_COV       = 2;
  localparam int IRQ_SHIFT     = 3;
  localparam int IRQ_DIV0      = 4;
  localparam int IRQ_DMA       = 5;
  localparam logic [5:0]  IRQ_RESET  = 6'h00;
endpackage
`default_nettype wire

/* File: hw/math_trap_status_control.sv */
/*
  math trap status and control register with apb slave and interrupt.
  assumes event inputs are one-cycle pulses from logic on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module math_trap_status_control
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        acc_a_overflow,
  input  wire logic        acc_b_overflow,
  input  wire logic        acc_a_catastrophic,
  input  wire logic        acc_b_catastrophic,
  input  wire logic        bad_shift,
  input  wire logic        zero_divide,
  input  wire logic        dma_ctrl_trap,
  output logic             arith_trap,
  output logic             dma_trap,
  output logic             nesting_disable,
  output logic             irq
);
  // =====================================================================
  // helpers
  // offsets are compared on the full byte address, so misaligned
  // accesses fall through to the error answer
  function automatic logic addr_hit
  (
    input logic [7:0] addr,
    input logic [7:0] offset
  );
    return (addr == offset);
  endfunction

  // merges the enabled byte lanes of a write into a 16-bit register;
  // lanes 2 and 3 have nothing behind them and are ignored
  function automatic logic [15:0] lane_merge
  (
    input logic [15:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0]  strb
  );
    logic [15:0] merged;
    merged = old_val;
    if (strb[1])
      merged[15:8] = wdata[15:8];
    if (strb[0])
      merged[7:0] = wdata[7:0];
    return merged;
  endfunction

  // =====================================================================
  // bus decode
  logic        access;
  logic        setup;
  logic        wr_en;
  logic        hit_ctrl;
  logic        hit_stat;
  logic        hit_mask;
  logic [15:0] trap_r;
  logic [5:0]  irq_status_r;
  logic [5:0]  irq_mask_r;
  logic [31:0] prdata_nxt;

  assign access   = psel && penable;
  assign setup    = psel && !penable;
  assign wr_en    = access && pwrite;
  assign hit_ctrl = addr_hit(paddr, math_trap_pkg::OFF_TRAP_CTRL);
  assign hit_stat = addr_hit(paddr, math_trap_pkg::OFF_IRQ_STATUS);
  assign hit_mask = addr_hit(paddr, math_trap_pkg::OFF_IRQ_MASK);
  // no wait states: every access phase completes in its first cycle
  assign pready   = 1'b1;
  // unmapped addresses answer with an error and read as zero
  assign pslverr  = access && !(hit_ctrl || hit_stat || hit_mask);

  // =====================================================================
  // qualified trap causes
  logic ova_trap;
  logic ovb_trap;
  logic cova_trap;
  logic covb_trap;
  logic math_trap;

  assign ova_trap  = acc_a_overflow
                     && trap_r[math_trap_pkg::BIT_OVA_EN];
  assign ovb_trap  = acc_b_overflow
                     && trap_r[math_trap_pkg::BIT_OVB_EN];
  assign cova_trap = acc_a_catastrophic
                     && trap_r[math_trap_pkg::BIT_COV_EN];
  assign covb_trap = acc_b_catastrophic
                     && trap_r[math_trap_pkg::BIT_COV_EN];
  assign math_trap = ova_trap || ovb_trap || cova_trap || covb_trap
                     || bad_shift || zero_divide;

  // =====================================================================
  // trap control and status register
  logic [15:0] set_bits;
  logic [15:0] trap_nxt;

  always_comb
  begin
    set_bits = 16'h0000;
    set_bits[math_trap_pkg::BIT_OVA_FLAG]  = ova_trap;
    set_bits[math_trap_pkg::BIT_OVB_FLAG]  = ovb_trap;
    set_bits[math_trap_pkg::BIT_COVA_FLAG] = cova_trap;
    set_bits[math_trap_pkg::BIT_COVB_FLAG] = covb_trap;
    set_bits[math_trap_pkg::BIT_SHIFT]     = bad_shift;
    set_bits[math_trap_pkg::BIT_DIV0]      = zero_divide;
    set_bits[math_trap_pkg::BIT_DMA]       = dma_ctrl_trap;
    set_bits[math_trap_pkg::BIT_ARITH]     = math_trap;
    trap_nxt = trap_r;
    if (wr_en && hit_ctrl)
      trap_nxt = lane_merge(trap_r, pwdata, pstrb);
    // bits 3:0 are not implemented: the mask keeps them at zero
    // flags may be written; hardware set wins over a same-cycle clear
    trap_nxt = ((trap_nxt & (math_trap_pkg::CTRL_MASK
                             | math_trap_pkg::FLAG_MASK))
                | set_bits);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      trap_r <= math_trap_pkg::TRAP_RESET;
    else
      trap_r <= trap_nxt;
  end

  // =====================================================================
  // interrupt status, write one to clear, and mask
  logic [5:0] irq_set;

  always_comb
  begin
    irq_set                           = 6'h00;
    irq_set[math_trap_pkg::IRQ_OVA]   = ova_trap;
    irq_set[math_trap_pkg::IRQ_OVB]   = ovb_trap;
    irq_set[math_trap_pkg::IRQ_COV]   = cova_trap || covb_trap;
    irq_set[math_trap_pkg::IRQ_SHIFT] = bad_shift;
    irq_set[math_trap_pkg::IRQ_DIV0]  = zero_divide;
    irq_set[math_trap_pkg::IRQ_DMA]   = dma_ctrl_trap;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_status_r <= math_trap_pkg::IRQ_RESET;
    else if (wr_en && hit_stat && pstrb[0])
      irq_status_r <= (irq_status_r & ~pwdata[5:0]) | irq_set;
    else
      irq_status_r <= irq_status_r | irq_set;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_r <= math_trap_pkg::IRQ_RESET;
    else if (wr_en && hit_mask && pstrb[0])
      irq_mask_r <= pwdata[5:0];
  end

  // =====================================================================
  // read data
  always_comb
  begin
    prdata_nxt = 32'h0000_0000;
    if (hit_ctrl)
      prdata_nxt[15:0] = trap_r;
    else if (hit_stat)
      prdata_nxt[5:0] = irq_status_r;
    else if (hit_mask)
      prdata_nxt[5:0] = irq_mask_r;
  end

  // registered in setup so the zero-wait access phase sees it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (setup)
      prdata <= prdata_nxt;
  end

  // =====================================================================
  // outputs to the core
  // registered so the core sees a clean one-cycle pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      arith_trap <= 1'b0;
    else
      arith_trap <= math_trap;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dma_trap <= 1'b0;
    else
      dma_trap <= dma_ctrl_trap;
  end

  assign nesting_disable = trap_r[math_trap_pkg::BIT_NEST_DIS];
  // level output: stays high until software clears or masks the cause
  assign irq             = |(irq_status_r & irq_mask_r);
endmodule
`default_nettype wire

/* File: tb/math_trap_monitor.sv */
/* checker: trap outputs against the event inputs.
   assumes it is bound onto math_trap_status_control. */
`timescale 1ns/1ns
`default_nettype none
module math_trap_monitor
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic acc_a_overflow,
  input wire logic acc_b_overflow,
  input wire logic acc_a_catastrophic,
  input wire logic acc_b_catastrophic,
  input wire logic bad_shift,
  input wire logic zero_divide,
  input wire logic dma_ctrl_trap,
  input wire logic arith_trap,
  input wire logic dma_trap,
  input wire logic nesting_disable,
  input wire logic irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================================================
  // trap pulses follow their causes by one cycle
  shift_trap_a: assert property (bad_shift |=> arith_trap)
    else $error("shift error gave no trap");
  div_trap_a: assert property (zero_divide |=> arith_trap)
    else $error("divide by zero gave no trap");
  dma_trap_a: assert property (dma_ctrl_trap |=> dma_trap)
    else $error("dma trap not passed on");
  dma_cause_a: assert property (
    dma_trap |-> $past(dma_ctrl_trap))
    else $error("dma trap without cause");
  // a trap with no cause would hide which source really trapped
  trap_cause_a: assert property (
    arith_trap |-> $past(acc_a_overflow | acc_b_overflow |
    acc_a_catastrophic | acc_b_catastrophic | bad_shift | zero_divide))
    else $error("math trap without cause");
  // nothing may be left over from before a reset once it is released
  reset_clear_a: assert property (
    $rose(presetn) |-> !arith_trap && !dma_trap
    && !irq && !nesting_disable)
    else $error("outputs not clear after reset");
endmodule
bind math_trap_status_control math_trap_monitor mon (.*);
`default_nettype wire

/* File: tb/core_trap_model.sv */
/* model of the core side: raises causes, counts traps.
   assumes cause bits map to the block's event inputs. */
`timescale 1ns/1ns
`default_nettype none
module core_trap_model
(
  input wire logic       pclk,
  input wire logic       arith_trap,
  input wire logic       dma_trap,
  output logic     [6:0] cause,
  output var int         traps
);
  // ====================================================
  // one-cycle cause pulses, launched after an edge
  initial cause = '0;
  initial traps = 0;
  always @(posedge pclk)
    if (arith_trap | dma_trap)
      traps <= traps + 1;
  task fire(input int i);
    @(posedge pclk) cause[i] <= 1'b1;
    @(posedge pclk) cause <= '0;
  endtask
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/* apb bench for the math trap status and control block.
   assumes the core model and bound checker are compiled in. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module testbench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [3:0] pstrb = 4'hf;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, arith_trap, dma_trap, nesting_disable, irq, err;
  logic [6:0] cause;
  int traps, num_errors = 0, checks_done = 0;
  localparam logic [7:0] A_CTL = math_trap_pkg::OFF_TRAP_CTRL;
  localparam logic [7:0] A_STA = math_trap_pkg::OFF_IRQ_STATUS;
  localparam logic [7:0] A_MSK = math_trap_pkg::OFF_IRQ_MASK;
  // expected control word per cause, the three enables included
  logic [15:0] fbit [7] = '{16'h4710, 16'h2710, 16'h1710, 16'h0f10,
    16'h0790, 16'h0750, 16'h0720};
  logic [5:0] ibit [7] = '{6'h01, 6'h02, 6'h04, 6'h04, 6'h08, 6'h10, 6'h20};
  always #2 pclk = ~pclk;
  math_trap_status_control dut (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .acc_a_overflow(cause[0]), .acc_b_overflow(cause[1]),
    .acc_a_catastrophic(cause[2]), .acc_b_catastrophic(cause[3]),
    .bad_shift(cause[4]), .zero_divide(cause[5]), .dma_ctrl_trap(cause[6]),
    .arith_trap, .dma_trap, .nesting_disable, .irq);
  core_trap_model core (.pclk, .arith_trap, .dma_trap, .cause, .traps);
  // ====================================================
  // bus access and closing report
  task end_of_test;
    if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin num_errors++; end_of_test; end
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      xfer(0, 8'(4 * k), 0); `CHK(rd, 32'h0)
    end
    xfer(1, A_CTL, 32'h0700);
    xfer(1, A_MSK, 32'h3f);
    for (int i = 0; i < 7; i++)
    begin
      core.fire(i);
      xfer(0, A_CTL, 0);
      `CHK(rd[15:0], fbit[i])
      xfer(0, A_STA, 0);
      `CHK(rd[5:0], ibit[i])
      #1 `CHK(irq, 1'b1)
      xfer(1, A_CTL, 32'h0700);
      xfer(1, A_STA, 32'h3f);
      #1 `CHK(irq, 1'b0)
    end
    `CHK(traps, 7)
    // enables off: overflow of either kind must stay silent
    xfer(1, A_CTL, 0);
    for (int i = 0; i < 4; i++) core.fire(i);
    xfer(0, A_CTL, 0);
    `CHK(rd[15:0], 16'h0)
    `CHK(traps, 7)
    xfer(1, A_MSK, 0);
    core.fire(4);
    #1 `CHK(irq, 1'b0)
    xfer(0, A_STA, 0);
    `CHK(rd[5:0], 6'h08)
    xfer(0, 8'h0c, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    // a reset in mid-run must clear control, mask and interrupt
    xfer(1, A_MSK, 32'h3f);
    xfer(1, A_CTL, 32'h8700);
    #1 `CHK({nesting_disable, irq}, 2'b11)
    @(posedge pclk) presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    #1 `CHK({nesting_disable, irq}, 2'b00)
    for (int k = 0; k < 3; k++)
    begin
      xfer(0, 8'(4 * k), 0); `CHK(rd, 32'h0)
    end
    end_of_test;
  end
endmodule
`default_nettype wire
